// ==== fifo_flag_defines.vh ====
// Constants shared by the flag FIFO: register offsets, field positions, reset values.
// Assumes inclusion by bare name from the design files of this folder.
`ifndef FIFO_FLAG_DEFINES_VH
`define FIFO_FLAG_DEFINES_VH

// Register byte offsets on the APB slave.
`define REG_STATUS        8'h00
`define REG_EMPTY_OFFSET  8'h04
`define REG_FULL_OFFSET   8'h08
`define REG_LEVEL         8'h0c
`define REG_IRQ_STATUS    8'h10
`define REG_IRQ_MASK      8'h14

// Status register fields.
`define ST_FALL_THROUGH_SELECT           0
`define ST_DDR            1
`define ST_OUT_VALID      2
`define ST_EMPTY_N        3
`define ST_FULL_N         4
`define ST_AEMPTY_N       5
`define ST_AFULL_N        6

// Interrupt event bits.
`define IRQ_BITS          6
`define EV_EMPTY          0
`define EV_FULL           1
`define EV_AEMPTY         2
`define EV_AFULL          3
`define EV_WR_REFUSED     4
`define EV_RD_REFUSED     5

// Default flag offsets chosen by the two offset-select straps.
`define OFFSET_HH         8'hff
`define OFFSET_LH         8'h7f
`define OFFSET_HL         8'h3f
`define OFFSET_LL         8'h07

// Register stages on flag outputs.
`define SYNC_STAGES_EF_FF 2
`define SYNC_STAGES_OR    3
`define SYNC_STAGES_IR    2

`endif

// ==== fifo_storage.v ====
// Word storage of the FIFO: one write port, one asynchronous read port.
// Assumes the caller never writes while the FIFO is full.
`timescale 1ns/1ps
`default_nettype none

module fifo_storage #(
    parameter WIDTH  = 40,
    parameter ADDR_W = 14
) (
    // Clock.
    input  wire              clock,
    // Write port.
    input  wire              wr_en,
    input  wire [ADDR_W-1:0] wr_addr,
    input  wire [WIDTH-1:0]  wr_data,
    // Read port.
    input  wire [ADDR_W-1:0] rd_addr,
    output wire [WIDTH-1:0]  rd_data
);

    reg [WIDTH-1:0] mem_q [0:(1<<ADDR_W)-1];

    // Storage carries no reset; the pointers alone say which words are valid.
    always @(posedge clock) begin
        if (wr_en) begin
            mem_q[wr_addr] <= wr_data;
        end
    end

    assign rd_data = mem_q[rd_addr];

endmodule // fifo_storage

`default_nettype wire

// ==== pipe_sync.v ====
// Chain of register stages that carries a value into the consuming domain.
// Assumes the source is a flop; the first stage is read only by the second.
`timescale 1ns/1ps
`default_nettype none

module pipe_sync #(
    parameter WIDTH  = 1,
    parameter STAGES = 2,
    parameter INIT   = 1'b0
) (
    // Clock and reset.
    input  wire             clock,
    input  wire             rst,
    // Data.
    input  wire [WIDTH-1:0] d_in,
    output wire [WIDTH-1:0] d_out
);

    reg [WIDTH-1:0] stage_q [0:STAGES-1];

    genvar i;
    generate
        for (i = 0; i < STAGES; i = i + 1) begin : g_stage
            always @(posedge clock) begin
                if (rst) begin
                    stage_q[i] <= {WIDTH{INIT}};
                end else begin
                    stage_q[i] <= (i == 0) ? d_in : stage_q[(i == 0) ? 0 : i-1];
                end
            end
        end
    endgenerate

    assign d_out = stage_q[STAGES-1];

endmodule // pipe_sync

`default_nettype wire

// ==== fifo_flag_core.v ====
// FIFO with standard and fall-through timing, status flags and an APB register file.
// Assumes writer and reader strobes are synchronous to clock; rst is master reset.
`timescale 1ns/1ps
`default_nettype none
`include "fifo_flag_defines.vh"

module fifo_flag_core #(
    parameter WIDTH  = 40,
    parameter ADDR_W = 14
) (
    // Clock and master reset.
    input  wire              clock,
    input  wire              rst,
    // Straps sampled during master reset.
    input  wire              fall_through_select,
    input  wire              ddr_mode,
    input  wire              offset_select_0,
    input  wire              offset_select_1,
    // Writer.
    input  wire              write_en_n,
    input  wire [WIDTH-1:0]  data_in,
    // Reader.
    input  wire              read_en_n,
    output reg  [WIDTH-1:0]  data_out_bus,
    // Status flags, all active low.
    output wire              empty_flag_n,
    output wire              full_flag_n,
    output reg               almost_empty_flag_n,
    output reg               almost_full_flag_n,
    output wire              output_ready_n,
    output wire              input_ready_n,
    // APB slave.
    input  wire              psel,
    input  wire              penable,
    input  wire              pwrite,
    input  wire [7:0]        paddr,
    input  wire [31:0]       pwdata,
    output reg  [31:0]       prdata,
    output reg               pready,
    output reg               pslverr,
    // Interrupt.
    output reg               irq
);

    localparam PW = ADDR_W + 1;
    localparam [PW-1:0] DEPTH_V = {1'b1, {ADDR_W{1'b0}}};

    reg             fall_through_select_q;
    reg             ddr_q;
    reg [ADDR_W-1:0] empty_off_q;
    reg [ADDR_W-1:0] full_off_q;
    reg [PW-1:0]    wr_ptr_q;
    reg [PW-1:0]    rd_ptr_q;
    reg             out_valid_q;
    reg [`IRQ_BITS-1:0] irq_status_q;
    reg [`IRQ_BITS-1:0] irq_mask_q;
    reg [`IRQ_BITS-1:0] irq_status_d;
    reg             empty_raw_q;
    reg             full_raw_q;
    reg             aempty_raw_q;
    reg             afull_raw_q;
    reg             ready_n_raw_q;
    reg [31:0]      rdata_d;
    reg             unmapped_d;

    wire [PW-1:0]    rd_ptr_ws;
    wire [PW-1:0]    wr_ptr_rs;
    wire [WIDTH-1:0] mem_rd_data;
    wire [PW-1:0]    wr_level;
    wire [PW-1:0]    rd_level;
    wire [PW-1:0]    rd_total;
    wire             wr_space;
    wire             rd_avail;
    wire             wr_take;
    wire             rd_req;
    wire             std_read;
    wire             fall_through_select_pop;
    wire             fall_through_select_load;
    wire             mem_read;
    wire             apb_access;
    wire             apb_wr;
    wire [7:0]       off_default;
    wire [`IRQ_BITS-1:0] events;

    // Each side sees the other's pointer two stages late, so its flags stay safe.
    pipe_sync #(.WIDTH(PW), .STAGES(2), .INIT(1'b0)) u_rd_to_wr (
        .clock (clock),
        .rst   (rst),
        .d_in  (rd_ptr_q),
        .d_out (rd_ptr_ws)
    );

    pipe_sync #(.WIDTH(PW), .STAGES(2), .INIT(1'b0)) u_wr_to_rd (
        .clock (clock),
        .rst   (rst),
        .d_in  (wr_ptr_q),
        .d_out (wr_ptr_rs)
    );

    fifo_storage #(.WIDTH(WIDTH), .ADDR_W(ADDR_W)) u_mem (
        .clock   (clock),
        .wr_en   (wr_take),
        .wr_addr (wr_ptr_q[ADDR_W-1:0]),
        .wr_data (data_in),
        .rd_addr (rd_ptr_q[ADDR_W-1:0]),
        .rd_data (mem_rd_data)
    );

    assign wr_level = wr_ptr_q - rd_ptr_ws;
    assign rd_level = wr_ptr_rs - rd_ptr_q;
    assign rd_total = rd_level + {{ADDR_W{1'b0}}, out_valid_q};
    assign wr_space = (wr_level != DEPTH_V);
    assign rd_avail = (rd_level != {PW{1'b0}});

    assign wr_take   = !write_en_n && wr_space;
    assign rd_req    = !read_en_n;
    assign std_read  = !fall_through_select_q && rd_req && rd_avail;
    assign fall_through_select_pop  = fall_through_select_q && rd_req && out_valid_q;
    assign fall_through_select_load = fall_through_select_q && rd_avail && (!out_valid_q || fall_through_select_pop);
    assign mem_read  = std_read || fall_through_select_load;

    // Mode and default offsets are caught while master reset is held.
    assign off_default = offset_select_1 ?
                         (offset_select_0 ? `OFFSET_HH : `OFFSET_HL) :
                         (offset_select_0 ? `OFFSET_LH : `OFFSET_LL);

    assign apb_access = psel && penable && pready;
    assign apb_wr     = apb_access && pwrite;

    always @(posedge clock) begin
        if (rst) begin
            fall_through_select_q      <= fall_through_select && !ddr_mode;
            ddr_q       <= ddr_mode;
            empty_off_q <= {{(ADDR_W-8){1'b0}}, off_default};
            full_off_q  <= {{(ADDR_W-8){1'b0}}, off_default};
        end else if (apb_wr && paddr == `REG_EMPTY_OFFSET) begin
            empty_off_q <= pwdata[ADDR_W-1:0];
        end else if (apb_wr && paddr == `REG_FULL_OFFSET) begin
            full_off_q  <= pwdata[ADDR_W-1:0];
        end
    end

    // Pointers and output register.
    always @(posedge clock) begin
        if (rst) begin
            wr_ptr_q     <= {PW{1'b0}};
            rd_ptr_q     <= {PW{1'b0}};
            out_valid_q  <= 1'b0;
            data_out_bus <= {WIDTH{1'b0}};
        end else begin
            if (wr_take) begin
                wr_ptr_q <= wr_ptr_q + {{ADDR_W{1'b0}}, 1'b1};
            end
            if (mem_read) begin
                rd_ptr_q     <= rd_ptr_q + {{ADDR_W{1'b0}}, 1'b1};
                data_out_bus <= mem_rd_data;
            end
            if (fall_through_select_load) begin
                out_valid_q <= 1'b1;
            end else if (fall_through_select_pop) begin
                out_valid_q <= 1'b0;
            end
        end
    end

    // Raw flag levels, each from its own side's count.
    always @(posedge clock) begin
        if (rst) begin
            empty_raw_q   <= 1'b0;
            full_raw_q    <= 1'b1;
            aempty_raw_q  <= 1'b0;
            afull_raw_q   <= 1'b1;
            ready_n_raw_q <= 1'b1;
        end else begin
            empty_raw_q   <= rd_avail;
            full_raw_q    <= wr_space;
            ready_n_raw_q <= !out_valid_q;
            if (fall_through_select_q) begin
                aempty_raw_q <= (rd_total > {1'b0, empty_off_q});
            end else begin
                aempty_raw_q <= (rd_level > {1'b0, empty_off_q});
            end
            afull_raw_q <= (wr_level < (DEPTH_V - {1'b0, full_off_q}));
        end
    end

    always @(posedge clock) begin
        if (rst) begin
            almost_empty_flag_n <= 1'b0;
            almost_full_flag_n  <= 1'b1;
        end else begin
            almost_empty_flag_n <= aempty_raw_q;
            almost_full_flag_n  <= afull_raw_q;
        end
    end

    pipe_sync #(.WIDTH(1), .STAGES(`SYNC_STAGES_EF_FF), .INIT(1'b0)) u_ef (
        .clock (clock),
        .rst   (rst),
        .d_in  (empty_raw_q),
        .d_out (empty_flag_n)
    );

    pipe_sync #(.WIDTH(1), .STAGES(`SYNC_STAGES_EF_FF), .INIT(1'b1)) u_ff (
        .clock (clock),
        .rst   (rst),
        .d_in  (full_raw_q),
        .d_out (full_flag_n)
    );

    pipe_sync #(.WIDTH(1), .STAGES(`SYNC_STAGES_OR), .INIT(1'b1)) u_or (
        .clock (clock),
        .rst   (rst),
        .d_in  (ready_n_raw_q),
        .d_out (output_ready_n)
    );

    pipe_sync #(.WIDTH(1), .STAGES(`SYNC_STAGES_IR), .INIT(1'b0)) u_ir (
        .clock (clock),
        .rst   (rst),
        .d_in  (!full_raw_q),
        .d_out (input_ready_n)
    );

    // Events are edges of the raw flags and refused strobes; almost-empty tests rd_level, so it is an edge in standard mode only.
    assign events[`EV_EMPTY]      = empty_raw_q && !rd_avail;
    assign events[`EV_FULL]       = full_raw_q && !wr_space;
    assign events[`EV_AEMPTY]     = aempty_raw_q && !(rd_level > {1'b0, empty_off_q});
    assign events[`EV_AFULL]      = afull_raw_q &&
                                    !(wr_level < (DEPTH_V - {1'b0, full_off_q}));
    assign events[`EV_WR_REFUSED] = !write_en_n && !wr_space;
    assign events[`EV_RD_REFUSED] = rd_req && (fall_through_select_q ? !out_valid_q : !rd_avail);

    // A set in the same cycle as a write-one clear wins.
    always @* begin
        irq_status_d = irq_status_q;
        if (apb_wr && paddr == `REG_IRQ_STATUS) begin
            irq_status_d = irq_status_q & ~pwdata[`IRQ_BITS-1:0];
        end
        irq_status_d = irq_status_d | events;
    end

    always @* begin
        rdata_d    = 32'h00000000;
        unmapped_d = 1'b0;
        case (paddr)
            `REG_STATUS: begin
                rdata_d[`ST_FALL_THROUGH_SELECT]      = fall_through_select_q;
                rdata_d[`ST_DDR]       = ddr_q;
                rdata_d[`ST_OUT_VALID] = out_valid_q;
                rdata_d[`ST_EMPTY_N]   = empty_flag_n;
                rdata_d[`ST_FULL_N]    = full_flag_n;
                rdata_d[`ST_AEMPTY_N]  = almost_empty_flag_n;
                rdata_d[`ST_AFULL_N]   = almost_full_flag_n;
            end
            `REG_EMPTY_OFFSET: rdata_d[ADDR_W-1:0] = empty_off_q;
            `REG_FULL_OFFSET:  rdata_d[ADDR_W-1:0] = full_off_q;
            `REG_LEVEL:        rdata_d[PW-1:0]     = wr_level;
            `REG_IRQ_STATUS:   rdata_d[`IRQ_BITS-1:0] = irq_status_q;
            `REG_IRQ_MASK:     rdata_d[`IRQ_BITS-1:0] = irq_mask_q;
            default:           unmapped_d = 1'b1;
        endcase
    end

    // The slave waits one access cycle so every answer leaves a flop.
    always @(posedge clock) begin
        if (rst) begin
            pready       <= 1'b0;
            prdata       <= 32'h00000000;
            pslverr      <= 1'b0;
            irq_status_q <= {`IRQ_BITS{1'b0}};
            irq_mask_q   <= {`IRQ_BITS{1'b0}};
            irq          <= 1'b0;
        end else begin
            pready  <= psel && penable && !pready;
            prdata  <= (psel && penable && !pready && !pwrite) ? rdata_d : 32'h00000000;
            pslverr <= psel && penable && !pready && unmapped_d;
            if (apb_wr && paddr == `REG_IRQ_MASK) begin
                irq_mask_q <= pwdata[`IRQ_BITS-1:0];
            end
            irq_status_q <= irq_status_d;
            irq          <= |(irq_status_d & irq_mask_q);
        end
    end

endmodule // fifo_flag_core

`default_nettype wire

// ==== fifo_flag_asserts.sv ====
// Checker for the flag FIFO ports: flag ordering, register stages, read gating, APB timing.
// Assumes binding to fifo_flag_core and the LL offsets (n = m = 7) with a depth well above n + m.
`timescale 1ns/1ps
`default_nettype none
module fifo_flag_asserts #(
    parameter WIDTH = 40
) (
    // Clock, reset and mode strap.
    input wire logic             clock,
    input wire logic             rst,
    input wire logic             fall_through_select,
    // Strobes and data.
    input wire logic             write_en_n,
    input wire logic             read_en_n,
    input wire logic [WIDTH-1:0] data_out_bus,
    // Flags.
    input wire logic             empty_flag_n,
    input wire logic             full_flag_n,
    input wire logic             almost_empty_flag_n,
    input wire logic             almost_full_flag_n,
    // APB handshake.
    input wire logic             psel,
    input wire logic             penable,
    input wire logic             pready
);
    logic std;
    assign std = !fall_through_select;
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // Six quiet cycles first, so no earlier word or read is still in flight.
    sequence s_first_write;
        (std && !empty_flag_n && write_en_n)[*6] ##1 !write_en_n;
    endsequence
    sequence s_read_at_full;
        (std && !full_flag_n && read_en_n)[*6] ##1 !read_en_n;
    endsequence
    sequence s_read_full_idle;
        (std && !full_flag_n && !read_en_n && write_en_n) ##1 write_en_n[*8];
    endsequence
    property p_empty_staged;
        s_first_write |=> !empty_flag_n[*2];
    endproperty
    a_empty_staged: assert property (p_empty_staged) else $error("empty flag too fast");
    property p_full_staged;
        s_read_at_full |=> !full_flag_n[*2];
    endproperty
    a_full_staged: assert property (p_full_staged) else $error("full flag too fast");
    property p_full_release;
        s_read_full_idle |-> full_flag_n;
    endproperty
    a_full_release: assert property (p_full_release) else $error("full not released");
    property p_full_af;
        std && !full_flag_n |-> !almost_full_flag_n;
    endproperty
    a_full_af: assert property (p_full_af) else $error("full without almost-full");
    property p_empty_ae;
        std && !empty_flag_n |-> !almost_empty_flag_n;
    endproperty
    a_empty_ae: assert property (p_empty_ae) else $error("empty without almost-empty");
    property p_af_ae;
        std && !almost_full_flag_n |-> almost_empty_flag_n;
    endproperty
    a_af_ae: assert property (p_af_ae) else $error("almost flags both low");
    property p_empty_not_full;
        std && !empty_flag_n |-> full_flag_n && almost_full_flag_n;
    endproperty
    a_empty_not_full: assert property (p_empty_not_full) else $error("empty and full");
    property p_data_needs_read;
        std && $changed(data_out_bus) |-> !$past(read_en_n);
    endproperty
    a_data_needs_read: assert property (p_data_needs_read) else $error("data without read");
    property p_apb_ready;
        psel && penable && !pready |=> pready;
    endproperty
    a_apb_ready: assert property (p_apb_ready) else $error("apb answer late");
endmodule // fifo_flag_asserts
`default_nettype wire

// ==== fifo_side_model.sv ====
// Writer and reader that face the FIFO ports, driven by bench requests.
// Assumes requests change just after a rising edge; strobes follow one edge later.
`timescale 1ns/1ps
`default_nettype none
module fifo_side_model (
    // Clock.
    input  wire logic        clock,
    // Requests from the bench.
    input  wire logic        wr_req,
    input  wire logic        rd_req,
    input  wire logic [39:0] wr_word,
    // Towards the FIFO.
    output logic             write_en_n,
    output logic             read_en_n,
    output logic [39:0]      data_in
);
    initial begin
        write_en_n = 1'b1;
        read_en_n = 1'b1;
        data_in = 40'h0;
    end
    always @(posedge clock) begin
        write_en_n <= ~wr_req;
        read_en_n <= ~rd_req;
        // Idle data lines toggle, so a stale word is never captured by luck.
        data_in <= wr_req ? wr_word : ~data_in;
    end
endmodule // fifo_side_model
`default_nettype wire

// ==== dual_clock_fifo_flag_timing_modes_bench.sv ====
// Self-checking bench for the flag FIFO: queue model, APB tasks, both timing modes.
// Assumes fifo_flag_core at ADDR_W 9 (512 words); straps are low until the second reset.
`timescale 1ns/1ps
`default_nettype none
module dual_clock_fifo_flag_timing_modes_bench;
    localparam int DEPTH = 512;
    localparam int NOFF = 7;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic        fall_through_select = 1'b0;
    logic        ddr_mode = 1'b0;
    logic        offset_select_0 = 1'b0;
    logic        offset_select_1 = 1'b0;
    logic        wr_req = 1'b0;
    logic        rd_req = 1'b0;
    logic [39:0] wr_word = 40'h0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    wire         write_en_n, read_en_n, empty_flag_n, full_flag_n, almost_empty_flag_n;
    wire         almost_full_flag_n, output_ready_n, input_ready_n, pready, pslverr, irq;
    wire  [39:0] data_in, data_out_bus;
    wire  [31:0] prdata;
    logic [39:0] q[$];
    logic [39:0] last = 40'h0;
    logic [31:0] rdata;
    logic        rerr;
    int          err_count = 0;
    int          tests_run = 0;
    int          wr_total = 0;
    integer      seed = 55;
    int          up[8] = '{1, 7, 8, 504, 505, 511, 512, 513};
    int          dn[7] = '{511, 505, 504, 8, 7, 1, 0};

    always #50 clock = ~clock;

    fifo_side_model i_fifo_side_model (.clock(clock), .wr_req(wr_req), .rd_req(rd_req),
        .wr_word(wr_word), .write_en_n(write_en_n), .read_en_n(read_en_n), .data_in(data_in));
    fifo_flag_core #(.WIDTH(40), .ADDR_W(9)) i_fifo_flag_core (
        .clock(clock), .rst(rst), .fall_through_select(fall_through_select),
        .ddr_mode(ddr_mode), .offset_select_0(offset_select_0),
        .offset_select_1(offset_select_1),
        .write_en_n(write_en_n), .data_in(data_in), .read_en_n(read_en_n),
        .data_out_bus(data_out_bus), .empty_flag_n(empty_flag_n), .full_flag_n(full_flag_n),
        .almost_empty_flag_n(almost_empty_flag_n), .almost_full_flag_n(almost_full_flag_n),
        .output_ready_n(output_ready_n), .input_ready_n(input_ready_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq));

    task automatic complete_run;
        if (err_count == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic check(input logic [39:0] seen, input logic [39:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge clock);
    endtask

    // The wait has no limit of its own; the watchdog ends a transfer that never answers.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Writes stream one word per cycle; the model drops words offered while full.
    task automatic push(input int n);
        logic [39:0] w;
        repeat (n) begin
            @(posedge clock);
            w = {8'($random(seed)), 32'($random(seed))};
            wr_req <= 1'b1;
            wr_word <= w;
            wr_total++;
            if (q.size() < DEPTH) q.push_back(w);
        end
        @(posedge clock);
        wr_req <= 1'b0;
    endtask

    task automatic pop(input int n);
        repeat (n) begin
            @(posedge clock);
            rd_req <= 1'b1;
            @(posedge clock);
            rd_req <= 1'b0;
            cycles(2);
            if (q.size() > 0) last = q.pop_front();
            check(data_out_bus, last);
        end
    endtask

    task automatic flags;
        int n;
        n = q.size();
        cycles(12);
        check(empty_flag_n, n != 0);
        check(full_flag_n, n != DEPTH);
        check(almost_empty_flag_n, n > NOFF);
        check(almost_full_flag_n, n < DEPTH - NOFF);
    endtask

    initial begin
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        apb(1'b1, 8'h14, 32'h3f);
        apb(1'b0, 8'h00, 32'h0);
        check(rdata[0], 1'b0);
        foreach (up[i]) begin
            push(up[i] - wr_total);
            flags();
        end
        apb(1'b0, 8'h0c, 32'h0);
        check(rdata, 40'(DEPTH));
        apb(1'b0, 8'h10, 32'h0);
        check(rdata[4:0] & 5'h12, 5'h12);
        check(irq, 1'b1);
        apb(1'b1, 8'h10, 32'h3f);
        apb(1'b1, 8'h14, 32'h0);
        check(irq, 1'b0);
        apb(1'b0, 8'h18, 32'h0);
        check(rerr, 1'b1);
        check(rdata, 40'h0);
        foreach (dn[i]) begin
            pop(q.size() - dn[i]);
            flags();
        end
        pop(1);
        flags();
        apb(1'b1, 8'h14, 32'h3f);
        cycles(2);
        check(irq, 1'b1);
        rst <= 1'b1;
        fall_through_select <= 1'b1;
        cycles(12);
        rst <= 1'b0;
        q.delete();
        wr_total = 0;
        push(1);
        // The word is taken two edges after the request; it must fall through on the third edge.
        cycles(4);
        check(data_out_bus, 40'h0);
        cycles(1);
        check(data_out_bus, q[0]);
        cycles(12);
        check(data_out_bus, q[0]);
        check(output_ready_n, 1'b0);
        check(input_ready_n, 1'b0);
        apb(1'b0, 8'h00, 32'h0);
        check(rdata[0], 1'b1);
        // A double-rate strap must force standard timing even with fall-through selected.
        rst <= 1'b1;
        ddr_mode <= 1'b1;
        offset_select_1 <= 1'b1;
        cycles(12);
        rst <= 1'b0;
        q.delete();
        apb(1'b0, 8'h00, 32'h0);
        check(rdata[1:0], 2'b10);
        apb(1'b0, 8'h08, 32'h0);
        check(rdata, 40'h3f);
        apb(1'b0, 8'h04, 32'h0);
        check(rdata, 40'h3f);
        apb(1'b1, 8'h04, 32'h5);
        apb(1'b0, 8'h04, 32'h0);
        check(rdata, 40'h5);
        push(1);
        flags();
        pop(1);
        flags();
        complete_run();
    end

    initial begin
        repeat (20000) @(posedge clock);
        err_count++;
        complete_run();
    end
endmodule // dual_clock_fifo_flag_timing_modes_bench

bind fifo_flag_core fifo_flag_asserts #(.WIDTH(WIDTH)) i_fifo_flag_asserts (
    .clock(clock), .rst(rst), .fall_through_select(fall_through_select),
    .write_en_n(write_en_n), .read_en_n(read_en_n), .data_out_bus(data_out_bus),
    .empty_flag_n(empty_flag_n), .full_flag_n(full_flag_n),
    .almost_empty_flag_n(almost_empty_flag_n), .almost_full_flag_n(almost_full_flag_n),
    .psel(psel), .penable(penable), .pready(pready));
`default_nettype wire
